// >>> rtl/sfsit_map.vh
// Functional notes
// - Word length code plus one gives bits
// - Interrupt register upper sixteen bits read zero
// - Tx empty flag: zero when off, else empty
// - Tx half flag: zero when off, else four or more free slots
// - Tx full flag when eight words queued
// - Rx ready flag when any word queued
// - Rx half flag at four or more words
// - Rx full flag when eight words queued
// - Rx overflow sets on overwrite, clears on read
// - Slave select-advance: over sixteen bits flags overflow
// - Word length overflow clears on rx read
// - Enables in bits 15:8 mirror flags
// - Test register upper sixteen bits read zero
// - Period counter steps 0x0421 in test, else 1
// - Loopback routes transmit data to receive path
// - Init and sync-transfer bits are test only
// - State readout codes zero through six
// - State readout codes seven through eleven
// - Rx level reports words held, zero to eight
// - Tx level reports words held, zero to eight
// - Slave rx advance: select edge or word length
`ifndef SFSIT_MAP_VH
`define SFSIT_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SFSIT_OFS_RX_DATA 8'h00
`define SFSIT_OFS_TX_DATA 8'h04
`define SFSIT_OFS_CTRL 8'h08
`define SFSIT_OFS_IRQ 8'h0C
`define SFSIT_OFS_TEST 8'h10
`define SFSIT_OFS_PCNT 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFSIT_CTL_WL_LSB 0
`define SFSIT_CTL_SWC 4
`define SFSIT_CTL_PEER 5
`define SFSIT_CTL_MASTER 6
`define SFSIT_CTL_GO 8
`define SFSIT_CTL_ON 9
`define SFSIT_IRQ_EN_LSB 8
`define SFSIT_TST_STEP 15
`define SFSIT_TST_LOOP 14
`define SFSIT_TST_INIT 13
`define SFSIT_TST_SYNC 12

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define SFSIT_WL_RST 4'h0
`define SFSIT_IEN_RST 8'h00
`define SFSIT_PCNT_RST 16'h0000
`define SFSIT_STEP_TEST 16'h0421
`define SFSIT_STEP_NORM 16'h0001
`define SFSIT_MAX_BITS 5'd16
`define SFSIT_BITS_SAT 5'd17

// ----------------------------------------
// State readout codes
// ----------------------------------------
`define SFSIT_ST_IDLE 4'h0
`define SFSIT_ST_EXCH 4'h1
`define SFSIT_ST_SEL_ON 4'h2
`define SFSIT_ST_SEL_CK 4'h3
`define SFSIT_ST_CK_DLY 4'h4
`define SFSIT_ST_START 4'h5
`define SFSIT_ST_COUNT 4'h6
`define SFSIT_ST_CK_SEL 4'h7
`define SFSIT_ST_SEL_HI 4'h8
`define SFSIT_ST_SEL_OFF 4'h9
`define SFSIT_ST_PULSE 4'hA
`define SFSIT_ST_READY 4'hB

`endif

// >>> rtl/sfsit_top.v
`timescale 1ns/1ps
`include "sfsit_map.vh"

module sfsit_top #(
    parameter DEPTH = 8,
    parameter WIDTH = 16,
    parameter HALF_DIV = 4
) (
    input wire CORE_CLK,
    input wire RST_N,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire SCK_IN,
    output reg SCK_OUT,
    output reg SCK_OE,
    input wire SEL_IN_N,
    output reg SEL_OUT_N,
    output reg SEL_OE,
    input wire DATA_IN,
    output reg DATA_OUT,
    input wire PEER_READY_N,
    output reg IRQ
);

// ----------------------------------------
// Local constants
// ----------------------------------------
// Levels are 4-bit fields, so depth is limited to 8
localparam AW = $clog2(DEPTH);
localparam [3:0] FULL = DEPTH[3:0];
localparam [3:0] HALF = DEPTH[4:1];
localparam [7:0] HD_M1 = HALF_DIV[7:0] - 8'd1;

localparam [11:0] S_IDLE = 12'h001;
localparam [11:0] S_EXCH = 12'h002;
localparam [11:0] S_SEL_ON = 12'h004;
localparam [11:0] S_SEL_CK = 12'h008;
localparam [11:0] S_CK_DLY = 12'h010;
localparam [11:0] S_START = 12'h020;
localparam [11:0] S_COUNT = 12'h040;
localparam [11:0] S_CK_SEL = 12'h080;
localparam [11:0] S_SEL_HI = 12'h100;
localparam [11:0] S_SEL_OFF = 12'h200;
localparam [11:0] S_PULSE = 12'h400;
localparam [11:0] S_READY = 12'h800;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [3:0] sync1;
reg [3:0] sync2;
reg [3:0] sync3;
reg ph_valid;
reg ph_write;
reg [7:0] ph_addr;
reg module_on;
reg master;
reg peer_wait;
reg select_waveform_ctl;
reg [3:0] word_length;
reg [7:0] ien;
reg period_step_test;
reg loopback;
reg sync_transfer_test;
reg init_pulse;
reg exchange_trigger;
reg [WIDTH-1:0] tx_queue [0:DEPTH-1];
reg [WIDTH-1:0] rx_queue [0:DEPTH-1];
reg [AW-1:0] tx_wp;
reg [AW-1:0] tx_rp;
reg [AW-1:0] rx_wp;
reg [AW-1:0] rx_rp;
reg [3:0] tx_level;
reg [3:0] rx_level;
reg rx_overflow_flag;
reg word_length_overflow_flag;
reg [11:0] state;
reg [15:0] shreg;
reg [4:0] bitcnt;
reg [7:0] div;
reg rx_sample;
reg tx_pop;
reg rx_push;
reg wlo_set;
reg [15:0] rx_word;
reg [15:0] pcnt;
reg [31:0] rdata;
reg [3:0] fsm_state_readout;

wire take = HSEL & HTRANS[1] & HREADY;
wire wr = ph_valid & ph_write;
wire rd = ph_valid & ~ph_write;
wire sck_rise = sync2[0] & ~sync3[0];
wire sck_fall = ~sync2[0] & sync3[0];
wire sel_fall = ~sync2[1] & sync3[1];
wire sel_rise = sync2[1] & ~sync3[1];
wire sel_act = ~sync2[1];
wire peer_fall = ~sync2[3] & sync3[3];
wire peer_low = ~sync2[3];
wire rx_bit = loopback ? DATA_OUT : sync2[2];
wire tick = (div == HD_M1);
wire [4:0] nbits = {1'b0, word_length} + 5'd1;
wire [4:0] bit_next = bitcnt + 5'd1;
wire [15:0] wl_mask = 16'hFFFF >> (4'd15 - word_length);
wire [15:0] sh_next = {shreg[14:0], rx_sample};
wire tx_avail = (tx_level != 4'd0);
wire [15:0] tx_head = tx_avail ? tx_queue[tx_rp] : 16'h0000;
wire tx_full_flag = (tx_level == FULL);
wire rx_full_flag = (rx_level == FULL);
wire tx_empty_flag = module_on & ~tx_avail;
wire tx_half_flag = module_on & ((FULL - tx_level) >= HALF);
wire rx_ready_flag = (rx_level != 4'd0);
wire rx_half_flag = (rx_level >= HALF);
wire [7:0] flags = {word_length_overflow_flag, rx_overflow_flag,
    rx_full_flag, rx_half_flag, rx_ready_flag, tx_full_flag,
    tx_half_flag, tx_empty_flag};
wire rd_rx_reg = rd & (ph_addr == `SFSIT_OFS_RX_DATA);
wire rx_pop = rd_rx_reg & rx_ready_flag;
wire tx_push = wr & (ph_addr == `SFSIT_OFS_TX_DATA) & module_on
    & ~tx_full_flag;
wire rx_over = rx_push & rx_full_flag & ~rx_pop;
wire go_set = wr & (ph_addr == `SFSIT_OFS_CTRL) & module_on & master
    & HWDATA[`SFSIT_CTL_GO];

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Third stage only feeds edge detection
always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        sync1 <= 4'hF;
        sync2 <= 4'hF;
        sync3 <= 4'hF;
    end
    else
    begin
        sync1 <= {PEER_READY_N, DATA_IN, SEL_IN_N, SCK_IN};
        sync2 <= sync1;
        sync3 <= sync2;
    end
end

// ----------------------------------------
// Bus slave
// ----------------------------------------
// One wait state on every transfer
always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        ph_valid <= 1'b0;
        ph_write <= 1'b0;
        ph_addr <= 8'h00;
        HREADYOUT <= 1'b1;
        HRESP <= 1'b0;
        HRDATA <= 32'h0000_0000;
    end
    else if (take)
    begin
        ph_valid <= 1'b1;
        ph_write <= HWRITE;
        ph_addr <= HADDR[7:0];
        HREADYOUT <= 1'b0;
    end
    else if (ph_valid)
    begin
        ph_valid <= 1'b0;
        HREADYOUT <= 1'b1;
        if (!ph_write)
            HRDATA <= rdata;
    end
end

always @*
begin
    case (state)
        S_IDLE: fsm_state_readout = `SFSIT_ST_IDLE;
        S_EXCH: fsm_state_readout = `SFSIT_ST_EXCH;
        S_SEL_ON: fsm_state_readout = `SFSIT_ST_SEL_ON;
        S_SEL_CK: fsm_state_readout = `SFSIT_ST_SEL_CK;
        S_CK_DLY: fsm_state_readout = `SFSIT_ST_CK_DLY;
        S_START: fsm_state_readout = `SFSIT_ST_START;
        S_COUNT: fsm_state_readout = `SFSIT_ST_COUNT;
        S_CK_SEL: fsm_state_readout = `SFSIT_ST_CK_SEL;
        S_SEL_HI: fsm_state_readout = `SFSIT_ST_SEL_HI;
        S_SEL_OFF: fsm_state_readout = `SFSIT_ST_SEL_OFF;
        S_PULSE: fsm_state_readout = `SFSIT_ST_PULSE;
        S_READY: fsm_state_readout = `SFSIT_ST_READY;
        default: fsm_state_readout = `SFSIT_ST_IDLE;
    endcase
end

always @*
begin
    case (ph_addr)
        `SFSIT_OFS_RX_DATA:
            rdata = {16'h0000, rx_ready_flag ? rx_queue[rx_rp] : 16'h0000};
        `SFSIT_OFS_CTRL:
            rdata = {22'h00_0000, module_on, exchange_trigger, 1'b0,
                master, peer_wait, select_waveform_ctl, word_length};
        `SFSIT_OFS_IRQ:
            rdata = {16'h0000, ien, flags};
        `SFSIT_OFS_TEST:
            rdata = {16'h0000, period_step_test, loopback, 1'b0,
                sync_transfer_test, fsm_state_readout, rx_level,
                tx_level};
        `SFSIT_OFS_PCNT:
            rdata = {16'h0000, pcnt};
        default:
            rdata = 32'h0000_0000;
    endcase
end

// ----------------------------------------
// Software registers
// ----------------------------------------
// Status, level and state bits have no write path
always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        module_on <= 1'b0;
        master <= 1'b0;
        peer_wait <= 1'b0;
        select_waveform_ctl <= 1'b0;
        word_length <= `SFSIT_WL_RST;
        ien <= `SFSIT_IEN_RST;
        period_step_test <= 1'b0;
        loopback <= 1'b0;
        sync_transfer_test <= 1'b0;
        init_pulse <= 1'b0;
    end
    else
    begin
        init_pulse <= 1'b0;
        if (wr && ph_addr == `SFSIT_OFS_CTRL)
        begin
            module_on <= HWDATA[`SFSIT_CTL_ON];
            master <= HWDATA[`SFSIT_CTL_MASTER];
            peer_wait <= HWDATA[`SFSIT_CTL_PEER];
            select_waveform_ctl <= HWDATA[`SFSIT_CTL_SWC];
            word_length <= HWDATA[`SFSIT_CTL_WL_LSB +: 4];
        end
        if (wr && ph_addr == `SFSIT_OFS_IRQ)
            ien <= HWDATA[`SFSIT_IRQ_EN_LSB +: 8];
        if (wr && ph_addr == `SFSIT_OFS_TEST)
        begin
            period_step_test <= HWDATA[`SFSIT_TST_STEP];
            loopback <= HWDATA[`SFSIT_TST_LOOP];
            sync_transfer_test <= HWDATA[`SFSIT_TST_SYNC];
            init_pulse <= HWDATA[`SFSIT_TST_INIT];
        end
    end
end

// ----------------------------------------
// Queues
// ----------------------------------------
always @(posedge CORE_CLK)
begin
    if (tx_push)
        tx_queue[tx_wp] <= HWDATA[WIDTH-1:0];
    if (rx_push)
        rx_queue[rx_wp] <= rx_word;
end

always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        tx_wp <= {AW{1'b0}};
        tx_rp <= {AW{1'b0}};
        rx_wp <= {AW{1'b0}};
        rx_rp <= {AW{1'b0}};
        tx_level <= 4'd0;
        rx_level <= 4'd0;
        rx_overflow_flag <= 1'b0;
        word_length_overflow_flag <= 1'b0;
    end
    else if (!module_on)
    begin
        tx_wp <= {AW{1'b0}};
        tx_rp <= {AW{1'b0}};
        rx_wp <= {AW{1'b0}};
        rx_rp <= {AW{1'b0}};
        tx_level <= 4'd0;
        rx_level <= 4'd0;
        rx_overflow_flag <= 1'b0;
        word_length_overflow_flag <= 1'b0;
    end
    else
    begin
        if (tx_push)
            tx_wp <= tx_wp + 1'b1;
        if (tx_pop)
            tx_rp <= tx_rp + 1'b1;
        if (tx_push && !tx_pop)
            tx_level <= tx_level + 4'd1;
        else if (tx_pop && !tx_push)
            tx_level <= tx_level - 4'd1;
        // Full queue drops its oldest word on a new arrival
        if (rx_push)
            rx_wp <= rx_wp + 1'b1;
        if (rx_pop || rx_over)
            rx_rp <= rx_rp + 1'b1;
        if (rx_push && !rx_pop && !rx_full_flag)
            rx_level <= rx_level + 4'd1;
        else if (rx_pop && !rx_push)
            rx_level <= rx_level - 4'd1;
        // Set wins over the read-clear
        if (rx_over)
            rx_overflow_flag <= 1'b1;
        else if (rd_rx_reg)
            rx_overflow_flag <= 1'b0;
        if (wlo_set)
            word_length_overflow_flag <= 1'b1;
        else if (rd_rx_reg)
            word_length_overflow_flag <= 1'b0;
    end
end

// ----------------------------------------
// Transfer engine
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        state <= S_IDLE;
        shreg <= 16'h0000;
        bitcnt <= 5'd0;
        div <= 8'h00;
        rx_sample <= 1'b0;
        tx_pop <= 1'b0;
        rx_push <= 1'b0;
        wlo_set <= 1'b0;
        rx_word <= 16'h0000;
        exchange_trigger <= 1'b0;
        SCK_OUT <= 1'b0;
        SEL_OUT_N <= 1'b1;
    end
    else if (!module_on || init_pulse)
    begin
        state <= S_IDLE;
        bitcnt <= 5'd0;
        div <= 8'h00;
        tx_pop <= 1'b0;
        rx_push <= 1'b0;
        wlo_set <= 1'b0;
        exchange_trigger <= 1'b0;
        SCK_OUT <= 1'b0;
        SEL_OUT_N <= 1'b1;
    end
    else
    begin
        div <= tick ? 8'h00 : div + 8'h01;
        tx_pop <= 1'b0;
        rx_push <= 1'b0;
        wlo_set <= 1'b0;
        if (go_set)
            exchange_trigger <= 1'b1;
        if (master)
        begin
            case (state)
                S_IDLE:
                    if (exchange_trigger && tx_avail)
                        state <= peer_wait ? S_EXCH : S_SEL_ON;
                S_EXCH:
                    if (peer_fall)
                        state <= S_SEL_ON;
                S_READY:
                    if (peer_low)
                        state <= S_SEL_ON;
                S_SEL_ON:
                    if (tick)
                    begin
                        SEL_OUT_N <= 1'b0;
                        state <= S_SEL_CK;
                    end
                S_SEL_CK:
                    if (tick)
                        state <= S_CK_DLY;
                S_CK_DLY:
                    if (tick)
                        state <= S_START;
                S_START:
                begin
                    shreg <= tx_head;
                    tx_pop <= 1'b1;
                    bitcnt <= 5'd0;
                    state <= S_COUNT;
                end
                S_COUNT:
                    if (tick && !SCK_OUT)
                    begin
                        SCK_OUT <= 1'b1;
                        rx_sample <= rx_bit;
                    end
                    else if (tick)
                    begin
                        SCK_OUT <= 1'b0;
                        shreg <= sh_next;
                        bitcnt <= bit_next;
                        if (bit_next == nbits)
                            state <= S_CK_SEL;
                    end
                S_CK_SEL:
                    if (tick)
                    begin
                        rx_push <= 1'b1;
                        rx_word <= shreg & wl_mask;
                        if (select_waveform_ctl)
                        begin
                            SEL_OUT_N <= 1'b1;
                            state <= S_SEL_HI;
                        end
                        else if (tx_avail)
                            state <= peer_wait ? S_READY : S_START;
                        else
                            state <= S_SEL_OFF;
                    end
                S_SEL_HI:
                    if (tick)
                        state <= S_PULSE;
                S_PULSE:
                    if (tick && tx_avail)
                        state <= peer_wait ? S_READY : S_SEL_ON;
                    else if (tick)
                        state <= S_SEL_OFF;
                S_SEL_OFF:
                begin
                    SEL_OUT_N <= 1'b1;
                    exchange_trigger <= 1'b0;
                    state <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
        else
        begin
            // Slave: sample on rising, shift on falling
            exchange_trigger <= 1'b0;
            SEL_OUT_N <= 1'b1;
            state <= sel_act ? S_COUNT : S_IDLE;
            if (sel_fall)
            begin
                shreg <= tx_head;
                tx_pop <= tx_avail;
                bitcnt <= 5'd0;
            end
            else if (sel_rise && select_waveform_ctl)
            begin
                rx_push <= 1'b1;
                rx_word <= shreg;
                wlo_set <= (bitcnt > `SFSIT_MAX_BITS);
            end
            else if (sel_act && sck_rise)
                rx_sample <= rx_bit;
            else if (sel_act && sck_fall)
            begin
                if (!select_waveform_ctl && bit_next == nbits)
                begin
                    rx_push <= 1'b1;
                    rx_word <= sh_next & wl_mask;
                    shreg <= tx_head;
                    tx_pop <= tx_avail;
                    bitcnt <= 5'd0;
                end
                else
                begin
                    shreg <= sh_next;
                    // Saturate so long bursts stay flagged
                    if (bitcnt != `SFSIT_BITS_SAT)
                        bitcnt <= bit_next;
                end
            end
        end
    end
end

// ----------------------------------------
// Period counter and pins
// ----------------------------------------
always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
        pcnt <= `SFSIT_PCNT_RST;
    else if (!module_on)
        pcnt <= `SFSIT_PCNT_RST;
    else if (tick)
        pcnt <= pcnt + (period_step_test ? `SFSIT_STEP_TEST
            : `SFSIT_STEP_NORM);
end

always @(posedge CORE_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        SCK_OE <= 1'b0;
        SEL_OE <= 1'b0;
        DATA_OUT <= 1'b0;
        IRQ <= 1'b0;
    end
    else
    begin
        SCK_OE <= module_on & master;
        SEL_OE <= module_on & master;
        DATA_OUT <= shreg[word_length];
        IRQ <= |(flags & ien);
    end
end

endmodule // sfsit_top

// >>> dv/sfsit_top_props.sv
`timescale 1ns/1ps
module sfsit_top_props #(
    parameter HALF_DIV = 4
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic SCK_OUT,
    input wire logic SCK_OE,
    input wire logic SEL_OUT_N,
    input wire logic SEL_OE,
    input wire logic IRQ
);
    logic [7:0] hi_cnt;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    // ----------------------------------------
    // Serial clock high time
    // ----------------------------------------
    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            hi_cnt <= 8'h00;
        else if (SCK_OUT)
            hi_cnt <= hi_cnt + 8'h01;
        else
            hi_cnt <= 8'h00;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("bus response not OKAY");
    a_wait_one: assert property (HSEL && HTRANS[1] && HREADY
        |=> !HREADYOUT ##1 HREADYOUT)
        else $error("data phase not one wait state");
    a_upper_zero: assert property (HRDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rdata_hold: assert property ($changed(HRDATA) |-> $rose(HREADYOUT))
        else $error("read data changed outside completion");
    a_sck_framed: assert property (SEL_OUT_N |-> !SCK_OUT)
        else $error("serial clock outside frame");
    a_oe_pair: assert property (SEL_OE == SCK_OE)
        else $error("select and clock enables differ");
    a_off_quiet: assert property (!SCK_OE |-> SEL_OUT_N && !SCK_OUT)
        else $error("link active while not master");
    a_sck_high: assert property ($fell(SCK_OUT) |-> hi_cnt == HALF_DIV)
        else $error("serial clock high time wrong");
    a_irq_reset: assert property ($rose(RST_N) |-> !IRQ)
        else $error("interrupt high after reset");
endmodule // sfsit_top_props

// >>> dv/sfsit_peer.sv
`timescale 1ns/1ps
module sfsit_peer #(
    parameter logic [15:0] REPLY = 16'hA5C3
) (
    input wire logic clk,
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    output wire logic miso,
    output logic [15:0] got
);
    logic [15:0] shreg = 16'h0000;
    logic sel_q = 1'b1;
    logic sck_q = 1'b0;
    logic flip = 1'b0;

    // Released line toggles so a stale bit never looks valid
    assign miso = sel_n ? flip : shreg[15];

    // ----------------------------------------
    // Phase 0 slave, MSB first
    // ----------------------------------------
    always @(posedge clk)
    begin
        sel_q <= sel_n;
        sck_q <= sck;
        flip <= ~flip;
        if (sel_q && !sel_n)
            shreg <= REPLY;
        else if (sck_q && !sck && !sel_n)
            shreg <= {shreg[14:0], 1'b0};
        if (!sck_q && sck && !sel_n)
            got <= {got[14:0], mosi};
    end
endmodule // sfsit_peer

// >>> dv/spi_fifo_status_irq_test_tb.sv
`timescale 1ns/1ps
`include "sfsit_map.vh"
module spi_fifo_status_irq_test_tb;
    logic CORE_CLK, RST_N, HSEL, HWRITE, SCK_IN, SEL_IN_N, PEER_READY_N;
    logic [31:0] HADDR, HWDATA, r;
    logic [1:0] HTRANS;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, SCK_OUT, SCK_OE, SEL_OUT_N, SEL_OE;
    wire DATA_IN, DATA_OUT, IRQ, HREADY;
    wire [15:0] got;
    int fail_count, tests_run, i, k;
    logic [15:0] words [0:8];
    logic [7:0] en;
    localparam logic [31:0] ctl_m = 32'h0000_024F;
    localparam logic [31:0] go = 32'h0000_0100;

    assign HREADY = HREADYOUT;

    sfsit_top #(.DEPTH(8), .WIDTH(16), .HALF_DIV(4)) i_sfsit_top (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
        .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
        .SEL_IN_N(SEL_IN_N), .SEL_OUT_N(SEL_OUT_N), .SEL_OE(SEL_OE),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .PEER_READY_N(PEER_READY_N),
        .IRQ(IRQ));

    sfsit_peer i_sfsit_peer (.clk(CORE_CLK), .sck(SCK_OUT),
        .sel_n(SEL_OUT_N), .mosi(DATA_OUT), .miso(DATA_IN), .got(got));

    initial
    begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    // ----------------------------------------
    // Bus and checking tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 100; n++)
        begin
            @(posedge CORE_CLK);
            if (HREADY === 1'b1)
                break;
        end
        if (n == 100)
        begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] w);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h00_0000, a};
        HWRITE <= wr;
        wait_ready();
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= w;
        wait_ready();
        r = HRDATA;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input string name);
        bus(1'b0, a, 32'h0000_0000);
        check(name, r, exp);
    endtask

    // Polls the busy bit; a long exchange stays under the bound
    task automatic exchange();
        int n;
        bus(1'b1, `SFSIT_OFS_CTRL, ctl_m | go);
        for (n = 0; n < 2000; n++)
        begin
            bus(1'b0, `SFSIT_OFS_CTRL, 32'h0000_0000);
            if (r[`SFSIT_CTL_GO] === 1'b0)
                break;
        end
        if (n == 2000)
        begin
            fail_count++;
            print_verdict();
        end
    endtask

    function automatic logic [31:0] irq_exp(input int tx, rx,
        input logic ovf, wlo);
        irq_exp = {16'h0000, en, wlo, ovf, rx == 8, rx >= 4, rx > 0,
            tx == 8, (8 - tx) >= 4, tx == 0};
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HTRANS = 2'b00;
        HADDR = 32'h0000_0000;
        HWRITE = 1'b0;
        HWDATA = 32'h0000_0000;
        SCK_IN = 1'b0;
        SEL_IN_N = 1'b1;
        PEER_READY_N = 1'b1;
        fail_count = 0;
        tests_run = 0;
        en = 8'h00;
        for (i = 0; i < 9; i++)
            words[i] = {i[3:0], 12'h5A3} ^ 16'h0C3C;
        repeat (3) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        @(posedge CORE_CLK);
        rd(`SFSIT_OFS_IRQ, 32'h0000_0000, "irq reset");
        rd(`SFSIT_OFS_TEST, 32'h0000_0000, "test reset");
        bus(1'b1, `SFSIT_OFS_TEST, 32'hFFFF_FFFF);
        rd(`SFSIT_OFS_TEST, 32'h0000_D000, "test bits");
        bus(1'b1, `SFSIT_OFS_TEST, 32'h0000_0000);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000, "unmapped");
        bus(1'b1, `SFSIT_OFS_CTRL, ctl_m);
        en = 8'h01;
        bus(1'b1, `SFSIT_OFS_IRQ, 32'hFFFF_01FF);
        rd(`SFSIT_OFS_IRQ, irq_exp(0, 0, 0, 0), "irq on");
        check("irq pin empty", IRQ, 32'h0000_0001);
        en = 8'h04;
        bus(1'b1, `SFSIT_OFS_IRQ, {16'h0000, en, 8'h00});
        for (i = 1; i <= 9; i++)
        begin
            k = (i > 8) ? 8 : i;
            bus(1'b1, `SFSIT_OFS_TX_DATA, {16'h0000, words[i - 1]});
            rd(`SFSIT_OFS_TEST, k, "tx level");
            rd(`SFSIT_OFS_IRQ, irq_exp(k, 0, 0, 0), "tx flags");
        end
        check("irq pin full", IRQ, 32'h0000_0001);
        bus(1'b1, `SFSIT_OFS_TEST, 32'h0000_C000);
        // Four calls apart is twelve cycles, three ticks
        bus(1'b0, `SFSIT_OFS_PCNT, 32'h0000_0000);
        k = r + 32'h0000_0C63;
        repeat (3) bus(1'b0, `SFSIT_OFS_PCNT, 32'h0000_0000);
        rd(`SFSIT_OFS_PCNT, k & 32'h0000_FFFF, "pcnt step");
        exchange();
        rd(`SFSIT_OFS_IRQ, irq_exp(0, 8, 0, 0), "rx full");
        check("irq pin off", IRQ, 32'h0000_0000);
        rd(`SFSIT_OFS_TEST, 32'h0000_C080, "rx level");
        bus(1'b1, `SFSIT_OFS_TX_DATA, {16'h0000, words[8]});
        exchange();
        rd(`SFSIT_OFS_IRQ, irq_exp(0, 8, 1, 0), "overflow");
        for (i = 1; i <= 8; i++)
        begin
            rd(`SFSIT_OFS_RX_DATA, words[i], "loop data");
            rd(`SFSIT_OFS_IRQ, irq_exp(0, 8 - i, 0, 0), "rx drain");
            rd(`SFSIT_OFS_TEST, 32'h0000_C000 | (8 - i) << 4, "rx cnt");
        end
        bus(1'b1, `SFSIT_OFS_TEST, 32'h0000_0000);
        bus(1'b1, `SFSIT_OFS_TX_DATA, 32'h0000_3C96);
        bus(1'b1, `SFSIT_OFS_CTRL, ctl_m | go | 32'h0000_0020);
        rd(`SFSIT_OFS_TEST, 32'h0000_0101, "peer wait");
        PEER_READY_N <= 1'b0;
        exchange();
        check("wire bits", got, 32'h0000_3C96);
        rd(`SFSIT_OFS_RX_DATA, 32'h0000_A5C3, "peer data");
        bus(1'b1, `SFSIT_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `SFSIT_OFS_CTRL, 32'h0000_0210);
        en = 8'h80;
        bus(1'b1, `SFSIT_OFS_IRQ, {16'h0000, en, 8'h00});
        // Link clock unrelated to the core clock, still outside the burst
        #7.5 SEL_IN_N = 1'b0;
        for (i = 0; i < 17; i++)
        begin
            #24 SCK_IN = 1'b1;
            #24 SCK_IN = 1'b0;
        end
        #24 SEL_IN_N = 1'b1;
        repeat (10) @(posedge CORE_CLK);
        rd(`SFSIT_OFS_IRQ, irq_exp(0, 1, 0, 1), "length ovf");
        check("irq pin length", IRQ, 32'h0000_0001);
        bus(1'b0, `SFSIT_OFS_RX_DATA, 32'h0000_0000);
        rd(`SFSIT_OFS_IRQ, irq_exp(0, 0, 0, 0), "ovf clear");
        check("irq pin clear", IRQ, 32'h0000_0000);
        print_verdict();
    end
endmodule // spi_fifo_status_irq_test_tb

bind sfsit_top sfsit_top_props #(.HALF_DIV(HALF_DIV)) i_sfsit_top_props (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SEL_OUT_N(SEL_OUT_N),
    .SEL_OE(SEL_OE), .IRQ(IRQ));
